/* inc/ncs_pkg.sv */
package ncs_pkg;
	localparam int          ADDR_W        = 5;
	localparam logic [4:0]  OFS_STATION   = 5'h00;
	localparam logic [4:0]  OFS_STATUS    = 5'h06;
	localparam logic [4:0]  OFS_QPAIRS    = 5'h08;
	localparam logic [4:0]  OFS_MTU       = 5'h0a;
	localparam logic [4:0]  OFS_SPEED     = 5'h0c;
	localparam logic [4:0]  OFS_DUPLEX    = 5'h10;
	localparam logic [4:0]  OFS_KEYLEN    = 5'h11;
	localparam logic [4:0]  OFS_TBLLEN    = 5'h12;
	localparam logic [4:0]  OFS_HASH      = 5'h14;
	localparam logic [4:0]  OFS_LAST      = 5'h17;
	localparam int          FB_MTU        = 3;
	localparam int          FB_STATION    = 5;
	localparam int          FB_STATUS     = 16;
	localparam int          FB_MQ         = 22;
	localparam int          FB_RSS        = 60;
	localparam int          FB_SPD_DPX    = 63;
	localparam int          ST_LINK_UP    = 0;
	localparam int          ST_ANNOUNCE   = 1;
	localparam logic [15:0] QP_MIN        = 16'h0001;
	localparam logic [15:0] QP_MAX        = 16'h8000;
	localparam logic [15:0] MTU_MIN       = 16'h0044;
	localparam logic [15:0] MTU_PREF      = 16'h0500;
	localparam logic [16:0] ETH_HDR_LEN   = 17'h0_000e;
	localparam logic [7:0]  KEYLEN_MIN    = 8'h28;
	localparam logic [15:0] TBLLEN_MIN    = 16'h0080;
	localparam logic [31:0] HASH_MASK     = 32'h0000_01ff;
	localparam logic [31:0] SPEED_UNKNOWN = 32'hffff_ffff;
	localparam logic [31:0] SPEED_MAX     = 32'h7fff_ffff;
	localparam logic [7:0]  DPX_FULL      = 8'h00;
	localparam logic [7:0]  DPX_HALF      = 8'h01;
	localparam logic [7:0]  DPX_UNKNOWN   = 8'hff;
endpackage : ncs_pkg

/* rtl/ncs_config_space.sv */
`timescale 1ns/10ps
`default_nettype none
module ncs_config_space
	import ncs_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [7:0]        rdata,
	input  wire logic [63:0]       offered_features,
	input  wire logic [63:0]       negotiated_features,
	input  wire logic              legacy_mode,
	input  wire logic              guest_big_endian,
	input  wire logic [47:0]       station_address_init,
	input  wire logic              link_up_in,
	input  wire logic              announce_request_flag,
	input  wire logic [15:0]       queue_pair_cfg,
	input  wire logic [15:0]       mtu_cfg,
	input  wire logic [31:0]       speed_in,
	input  wire logic [7:0]        duplex_in,
	input  wire logic [7:0]        key_length_cfg,
	input  wire logic [15:0]       table_length_cfg,
	input  wire logic [31:0]       hash_types_cfg,
	input  wire logic              pkt_valid,
	input  wire logic              pkt_is_rx,
	input  wire logic [15:0]       pkt_len,
	output logic                   pkt_done,
	output logic                   pkt_accept,
	output logic                   config_changed
);

	typedef struct packed {
		logic        loaded;
		logic [47:0] station;
		logic [15:0] mtu;
		logic [31:0] speed;
		logic [7:0]  duplex;
		logic [1:0]  status;
		logic [7:0]  rdata;
		logic        pkt_done;
		logic        pkt_accept;
		logic        changed;
	} ncs_state_s;

	ncs_state_s st;
	ncs_state_s next_st;

	logic [15:0] qp_clamp;
	logic [15:0] mtu_clamp;
	logic [7:0]  key_clamp;
	logic [15:0] tbl_clamp;
	logic [31:0] speed_clean;
	logic [7:0]  duplex_clean;
	logic [15:0] status_word;
	logic [15:0] status_le;
	logic [15:0] qp_le;
	logic [31:0] hash_caps;
	logic [16:0] frame_limit;
	logic        mtu_neg;
	logic        hold_link;
	logic [7:0]  rd_byte;

	always_comb begin
		if (queue_pair_cfg < QP_MIN)
			qp_clamp = QP_MIN;
		else if (queue_pair_cfg > QP_MAX)
			qp_clamp = QP_MAX;
		else
			qp_clamp = queue_pair_cfg;
		// Preferred floor also covers the hard floor; 16 bits cap the top
		mtu_clamp = (mtu_cfg < MTU_PREF) ? MTU_PREF : mtu_cfg;
		key_clamp = (key_length_cfg < KEYLEN_MIN) ? KEYLEN_MIN
			: key_length_cfg;
		tbl_clamp = (table_length_cfg < TBLLEN_MIN) ? TBLLEN_MIN
			: table_length_cfg;
		hash_caps = hash_types_cfg & HASH_MASK;
		// Out-of-range speed collapses to the unknown code
		speed_clean = (speed_in > SPEED_MAX) ? SPEED_UNKNOWN : speed_in;
		if (duplex_in == DPX_FULL || duplex_in == DPX_HALF)
			duplex_clean = duplex_in;
		else
			duplex_clean = DPX_UNKNOWN;
		status_word = {14'h0000, st.status};
		// Legacy big-endian guests see these two fields swapped
		if (legacy_mode && guest_big_endian) begin
			status_le = {status_word[7:0], status_word[15:8]};
			qp_le     = {qp_clamp[7:0], qp_clamp[15:8]};
		end else begin
			status_le = status_word;
			qp_le     = qp_clamp;
		end
		mtu_neg     = negotiated_features[FB_MTU];
		frame_limit = {1'b0, st.mtu} + ETH_HDR_LEN;
		hold_link   = negotiated_features[FB_SPD_DPX]
			&& negotiated_features[FB_STATUS]
			&& st.status[ST_LINK_UP];
	end

	// Byte view of the packed layout; absent fields read zero
	always_comb begin
		rd_byte = 8'h00;
		case (addr)
			5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: begin
				rd_byte = st.station[8*(addr-OFS_STATION) +: 8];
			end
			5'h06, 5'h07: begin
				if (offered_features[FB_STATUS])
					rd_byte = status_le[8*(addr-OFS_STATUS) +: 8];
			end
			5'h08, 5'h09: begin
				if (offered_features[FB_MQ] || offered_features[FB_RSS])
					rd_byte = qp_le[8*(addr-OFS_QPAIRS) +: 8];
			end
			5'h0a, 5'h0b: begin
				if (offered_features[FB_MTU])
					rd_byte = st.mtu[8*(addr-OFS_MTU) +: 8];
			end
			5'h0c, 5'h0d, 5'h0e, 5'h0f: begin
				if (offered_features[FB_SPD_DPX])
					rd_byte = st.speed[8*(addr-OFS_SPEED) +: 8];
			end
			5'h10: begin
				if (offered_features[FB_SPD_DPX])
					rd_byte = st.duplex;
			end
			5'h11: begin
				if (offered_features[FB_RSS])
					rd_byte = key_clamp;
			end
			5'h12, 5'h13: begin
				if (offered_features[FB_RSS])
					rd_byte = tbl_clamp[8*(addr-OFS_TBLLEN) +: 8];
			end
			5'h14, 5'h15, 5'h16, 5'h17: begin
				if (offered_features[FB_RSS])
					rd_byte = hash_caps[8*(addr-OFS_HASH) +: 8];
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.loaded = 1'b1;
		// Address and transfer unit are taken once, after reset release
		if (!st.loaded) begin
			next_st.station = station_address_init;
			next_st.mtu     = mtu_clamp;
		end
		// Only a legacy driver may overwrite the station address
		if (wr && legacy_mode && addr <= (OFS_STATION + 5'h05))
			next_st.station[8*addr +: 8] = wdata;
		next_st.status = {announce_request_flag, link_up_in};
		if (!hold_link) begin
			next_st.speed  = speed_clean;
			next_st.duplex = duplex_clean;
		end
		next_st.rdata = rd ? rd_byte : 8'h00;
		next_st.changed = st.loaded && (next_st.status != st.status
			|| next_st.speed != st.speed
			|| next_st.duplex != st.duplex);
		next_st.pkt_done = pkt_valid;
		next_st.pkt_accept = 1'b0;
		if (pkt_valid) begin
			if (!mtu_neg)
				next_st.pkt_accept = 1'b1;
			else if (pkt_is_rx)
				next_st.pkt_accept = {1'b0, pkt_len} <= frame_limit;
			else
				next_st.pkt_accept = {1'b0, pkt_len} <= frame_limit;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= '0;
			st.speed  <= SPEED_UNKNOWN;
			st.duplex <= DPX_UNKNOWN;
		end else begin
			st <= next_st;
		end
	end

	assign rdata          = st.rdata;
	assign pkt_done       = st.pkt_done;
	assign pkt_accept     = st.pkt_accept;
	assign config_changed = st.changed;

	logic        prev_valid;
	logic [15:0] prev_mtu;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prev_valid <= 1'b0;
			prev_mtu   <= 16'h0000;
		end else begin
			prev_valid <= st.loaded;
			prev_mtu   <= st.mtu;
		end
	end

	mtu_stable_a: assert property (@(posedge ref_clk) disable iff (rst)
		prev_valid && st.loaded |-> st.mtu == prev_mtu)
		else $error("transfer unit changed after being set");
	mtu_range_a: assert property (@(posedge ref_clk) disable iff (rst)
		st.loaded |-> st.mtu >= MTU_PREF)
		else $error("transfer unit below floor");
	read_only_a: assert property (@(posedge ref_clk) disable iff (rst)
		st.loaded && !legacy_mode ##1 st.loaded |->
		st.station == $past(st.station))
		else $error("station address changed on modern interface");
	legacy_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
		st.loaded && wr && legacy_mode && addr == 5'h02 |=>
		st.station[23:16] == $past(wdata))
		else $error("legacy address write lost");
	speed_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		hold_link |=> st.speed == $past(st.speed)
		&& st.duplex == $past(st.duplex))
		else $error("speed or duplex moved while link up");
	duplex_code_a: assert property (@(posedge ref_clk) disable iff (rst)
		st.duplex == DPX_FULL || st.duplex == DPX_HALF
		|| st.duplex == DPX_UNKNOWN)
		else $error("illegal duplex code");

	// Field views and floors
	station_low_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_STATION |=> rdata == $past(st.station[7:0]))
		else $error("station address low byte mismatch");
	station_high_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_STATION + 5'h05
		|=> rdata == $past(st.station[47:40]))
		else $error("station address high byte mismatch");
	mtu_view_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_MTU && offered_features[FB_MTU]
		|=> rdata == $past(st.mtu[7:0]))
		else $error("transfer unit byte mismatch");
	qp_range_a: assert property (@(posedge ref_clk) disable iff (rst)
		qp_clamp >= QP_MIN && qp_clamp <= QP_MAX)
		else $error("queue pair limit out of range");
	key_floor_a: assert property (@(posedge ref_clk) disable iff (rst)
		key_clamp >= KEYLEN_MIN)
		else $error("hash key length below floor");
	tbl_floor_a: assert property (@(posedge ref_clk) disable iff (rst)
		tbl_clamp >= TBLLEN_MIN)
		else $error("steering table length below floor");
	hash_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
		(hash_caps & ~HASH_MASK) == 32'h0000_0000)
		else $error("undefined hash type bit set");
	key_view_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_KEYLEN && offered_features[FB_RSS]
		|=> rdata >= KEYLEN_MIN)
		else $error("hash key length read below floor");
	hash_view_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_HASH + 5'h01 && offered_features[FB_RSS]
		|=> rdata[7:1] == 7'h00)
		else $error("hash mask upper bits read nonzero");
	speed_view_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_SPEED + 5'h03 && offered_features[FB_SPD_DPX]
		|=> rdata == $past(st.speed[31:24]))
		else $error("speed top byte mismatch");
	duplex_view_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_DUPLEX && offered_features[FB_SPD_DPX]
		|=> rdata == $past(st.duplex))
		else $error("duplex byte mismatch");
	qp_swap_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_QPAIRS && offered_features[FB_MQ]
		&& legacy_mode && guest_big_endian
		|=> rdata == $past(qp_clamp[15:8]))
		else $error("legacy queue pair order wrong");
	status_swap_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_STATUS + 5'h01 && offered_features[FB_STATUS]
		&& legacy_mode && guest_big_endian
		|=> rdata == {6'h00, $past(st.status)})
		else $error("legacy status order wrong");

	// Absent and unmapped fields read zero
	unmapped_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr > OFS_LAST |=> rdata == 8'h00)
		else $error("unmapped offset read nonzero");
	absent_status_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_STATUS && !offered_features[FB_STATUS]
		|=> rdata == 8'h00)
		else $error("absent status field read nonzero");
	absent_qp_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_QPAIRS && !offered_features[FB_MQ]
		&& !offered_features[FB_RSS] |=> rdata == 8'h00)
		else $error("absent queue pair field read nonzero");
	absent_mtu_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_MTU && !offered_features[FB_MTU]
		|=> rdata == 8'h00)
		else $error("absent transfer unit read nonzero");
	absent_speed_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_SPEED && !offered_features[FB_SPD_DPX]
		|=> rdata == 8'h00)
		else $error("absent speed field read nonzero");
	absent_rss_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_HASH && !offered_features[FB_RSS]
		|=> rdata == 8'h00)
		else $error("absent hash mask read nonzero");
	read_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
		!rd |=> rdata == 8'h00)
		else $error("read data outside read cycle");

	// Register capture and update paths
	status_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |=> st.status == $past({announce_request_flag, link_up_in}))
		else $error("status bits did not follow inputs");
	changed_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
		st.loaded && link_up_in != st.status[ST_LINK_UP]
		|=> config_changed)
		else $error("link change not notified");
	speed_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
		!hold_link |=> st.speed == $past(speed_clean))
		else $error("speed not updated");
	duplex_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
		!hold_link |=> st.duplex == $past(duplex_clean))
		else $error("duplex not updated");
	mtu_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
		!st.loaded |=> st.mtu == $past(mtu_clamp))
		else $error("transfer unit not captured");
	modern_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
		st.loaded && wr && !legacy_mode
		|=> st.station == $past(st.station) && st.mtu == $past(st.mtu))
		else $error("modern write changed a field");

	// Frame check handshake, speed code and remaining field reads
	pkt_done_a: assert property (@(posedge ref_clk) disable iff (rst)
		pkt_valid |=> pkt_done)
		else $error("frame check not answered");
	pkt_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
		!pkt_valid |=> !pkt_done && !pkt_accept)
		else $error("frame result without request");
	free_pass_a: assert property (@(posedge ref_clk) disable iff (rst)
		pkt_valid && !mtu_neg |=> pkt_accept)
		else $error("frame refused without transfer unit limit");
	rx_pass_a: assert property (@(posedge ref_clk) disable iff (rst)
		pkt_valid && pkt_is_rx && mtu_neg
		&& {1'b0, pkt_len} <= frame_limit |=> pkt_accept)
		else $error("in-limit received frame refused");
	speed_code_a: assert property (@(posedge ref_clk) disable iff (rst)
		st.speed <= SPEED_MAX || st.speed == SPEED_UNKNOWN)
		else $error("illegal speed code");
	absent_field_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_DUPLEX && !offered_features[FB_SPD_DPX]
		|=> rdata == 8'h00)
		else $error("absent duplex field read nonzero");
	qp_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_QPAIRS && offered_features[FB_MQ]
		&& !legacy_mode && queue_pair_cfg == 16'h0000
		|=> rdata == 8'h01)
		else $error("queue pair floor not applied");
	rx_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
		pkt_valid && pkt_is_rx && mtu_neg
		&& {1'b0, pkt_len} > frame_limit |=> pkt_done && !pkt_accept)
		else $error("oversize received frame passed");
	tx_pass_a: assert property (@(posedge ref_clk) disable iff (rst)
		pkt_valid && !pkt_is_rx && {1'b0, pkt_len} <= frame_limit
		|=> pkt_done && pkt_accept)
		else $error("in-limit transmit frame refused");
	status_map_a: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == OFS_STATUS && offered_features[FB_STATUS]
		&& !legacy_mode |=> rdata == {6'h00, $past(st.status)})
		else $error("status byte mismatch");

	link_flap_c: cover property (@(posedge ref_clk) disable iff (rst)
		config_changed ##[1:20] config_changed);
	rx_drop_c: cover property (@(posedge ref_clk) disable iff (rst)
		pkt_done && !pkt_accept);
	legacy_wr_c: cover property (@(posedge ref_clk) disable iff (rst)
		wr && legacy_mode);
	hold_c: cover property (@(posedge ref_clk) disable iff (rst)
		hold_link && speed_clean != st.speed);

endmodule : ncs_config_space
`default_nettype wire

/* verif/ncs_config_space_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ncs_config_space_tb_top import ncs_pkg::*;;
	localparam logic [63:0] FEATS = 64'h9000_0000_0041_0028;
	// Row: offset in high byte, expected read byte in low byte
	localparam logic [15:0] ROWS [32] = '{
		16'h0011, 16'h0122, 16'h0233, 16'h0344, 16'h0455, 16'h0566,
		16'h0602, 16'h0700, 16'h0800, 16'h0980, 16'h0a00, 16'h0b05,
		16'h0cff, 16'h0dff, 16'h0eff, 16'h0fff, 16'h10ff, 16'h1128,
		16'h1280, 16'h1300, 16'h14ff, 16'h1501, 16'h1600, 16'h1700,
		16'h1800, 16'h1900, 16'h1a00, 16'h1b00, 16'h1c00, 16'h1d00,
		16'h1e00, 16'h1f00};
	logic              ref_clk = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic [7:0]        wdata = 8'h00;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic [7:0]        rdata;
	logic [63:0]       offered_features = FEATS;
	logic [63:0]       negotiated_features = FEATS;
	logic              legacy_mode = 1'b0;
	logic              guest_big_endian = 1'b0;
	logic [47:0]       station_address_init = 48'h6655_4433_2211;
	logic              link_up_in = 1'b0;
	logic              announce_request_flag = 1'b1;
	logic [15:0]       queue_pair_cfg = 16'h9000;
	logic [15:0]       mtu_cfg = 16'h0100;
	logic [31:0]       speed_in = 32'h8000_0000;
	logic [7:0]        duplex_in = 8'h05;
	logic [7:0]        key_length_cfg = 8'h10;
	logic [15:0]       table_length_cfg = 16'h0040;
	logic [31:0]       hash_types_cfg = 32'hffff_ffff;
	logic              pkt_valid = 1'b0;
	logic              pkt_is_rx = 1'b0;
	logic [15:0]       pkt_len = 16'h0000;
	logic              pkt_done;
	logic              pkt_accept;
	logic              config_changed;
	int                n_errors = 0;
	int                check_count = 0;

	ncs_config_space u_ncs_config_space (.ref_clk, .rst, .addr, .wdata, .wr,
		.rd, .rdata, .offered_features, .negotiated_features, .legacy_mode,
		.guest_big_endian, .station_address_init, .link_up_in,
		.announce_request_flag, .queue_pair_cfg, .mtu_cfg, .speed_in,
		.duplex_in, .key_length_cfg, .table_length_cfg, .hash_types_cfg,
		.pkt_valid, .pkt_is_rx, .pkt_len, .pkt_done, .pkt_accept,
		.config_changed);

	always #50 ref_clk = ~ref_clk;

	task automatic chk_byte(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk_byte

	task automatic chk_flag(input string what, input logic exp,
		input logic got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %b got %b", what, exp, got);
		end
	endtask : chk_flag

	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		chk_byte("rdata", exp, rdata);
	endtask : rd_chk

	task automatic wr_byte(input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : wr_byte

	task automatic pkt_chk(input logic rx, input logic [15:0] len,
		input logic exp);
		@(posedge ref_clk);
		pkt_valid <= 1'b1;
		pkt_is_rx <= rx;
		pkt_len   <= len;
		@(posedge ref_clk);
		pkt_valid <= 1'b0;
		#1;
		chk_flag("pkt_done", 1'b1, pkt_done);
		chk_flag("pkt_accept", exp, pkt_accept);
	endtask : pkt_chk

	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (3000) @(posedge ref_clk);
		n_errors++;
		give_verdict();
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		foreach (ROWS[i]) begin
			rd_chk(ROWS[i][12:8], ROWS[i][7:0]);
		end
		wr_byte(5'h00, 8'haa);
		rd_chk(5'h00, 8'h11);
		wr_byte(5'h0a, 8'h44);
		rd_chk(5'h0a, 8'h00);
		@(posedge ref_clk);
		legacy_mode      <= 1'b1;
		guest_big_endian <= 1'b1;
		wr_byte(5'h02, 8'h5a);
		rd_chk(5'h02, 8'h5a);
		rd_chk(5'h07, 8'h02);
		rd_chk(5'h08, 8'h80);
		@(posedge ref_clk);
		legacy_mode <= 1'b0;
		speed_in    <= 32'h0000_2710;
		duplex_in   <= 8'h01;
		@(posedge ref_clk);
		#1;
		chk_flag("config_changed", 1'b1, config_changed);
		@(posedge ref_clk);
		#1;
		chk_flag("config_changed", 1'b0, config_changed);
		rd_chk(5'h0d, 8'h27);
		@(posedge ref_clk);
		link_up_in <= 1'b1;
		@(posedge ref_clk);
		speed_in  <= 32'h0000_03e8;
		duplex_in <= 8'h00;
		repeat (3) @(posedge ref_clk);
		rd_chk(5'h0c, 8'h10);
		rd_chk(5'h10, 8'h01);
		rd_chk(5'h06, 8'h03);
		@(posedge ref_clk);
		link_up_in <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rd_chk(5'h0c, 8'he8);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			duplex_in <= 8'(32'h7fff_0100 >> (8 * i));
			repeat (2) @(posedge ref_clk);
			rd_chk(5'h10, 8'(32'hffff_0100 >> (8 * i)));
		end
		@(posedge ref_clk);
		offered_features <= 64'h0;
		mtu_cfg          <= 16'hffff;
		repeat (2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			rd_chk(5'(64'h1412_1110_0c0a_0806 >> (8 * i)), 8'h00);
		end
		rd_chk(5'h02, 8'h5a);
		@(posedge ref_clk);
		offered_features <= FEATS;
		queue_pair_cfg   <= 16'h0000;
		repeat (2) @(posedge ref_clk);
		rd_chk(5'h0b, 8'h05);
		rd_chk(5'h08, 8'h01);
		rd_chk(5'h09, 8'h00);
		pkt_chk(1'b1, 16'h050e, 1'b1);
		pkt_chk(1'b1, 16'h050f, 1'b0);
		pkt_chk(1'b0, 16'h050e, 1'b1);
		@(posedge ref_clk);
		negotiated_features <= 64'h9000_0000_0041_0020;
		pkt_chk(1'b1, 16'hffff, 1'b1);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		chk_byte("rdata", 8'h00, rdata);
		chk_flag("pkt_done", 1'b0, pkt_done);
		chk_flag("config_changed", 1'b0, config_changed);
		repeat (2) @(posedge ref_clk);
		rd_chk(5'h02, 8'h33);
		give_verdict();
	end
endmodule : ncs_config_space_tb_top
`default_nettype wire
